// ==== bpsio_pkg.sv ====
// Constants for the bracket panel soft input/output port.
// Assumes one 100 MHz clock and an 8-bit low-speed bus with strobes.
package bpsio_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W   = 8;
  localparam int JUMPER_W = 3;
  localparam int SWITCH_W = 4;
  localparam int SYNC_W   = 4 + JUMPER_W + SWITCH_W + DATA_W;

  // ----------------------------------------------------------------
  // Register field positions
  // ----------------------------------------------------------------
  localparam int TOGGLE_BIT = 7;
  localparam int RED_BIT    = 2;
  localparam int GREEN_BIT  = 1;
  localparam int AMBER_BIT  = 0;
  localparam int JUMPER_LSB = 4;
  localparam int SWITCH_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic LAMP_OFF   = 1'b1;
  localparam logic TOGGLE_RST = 1'b0;
  // Enable low, select and strobes idle high, jumpers/switch/data low
  localparam logic [SYNC_W-1:0] SYNC_RST = 19'h3_8000;

endpackage

// ==== bpsio_sync.sv ====
// Three-stage input filter for pins from outside the clock domain.
// Assumes nothing beyond the clock and asynchronous reset.
`timescale 1ns/100ps
module bpsio_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Pins and filtered levels
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;
  logic [W-1:0] pinOut_nxt;

  // ----------------------------------------------------------------
  // Acceptance
  // ----------------------------------------------------------------
  // Stage one is read only by stage two; a level counts once 2 and 3 agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : gAgree
      assign pinOut_nxt[i] = (stage2_r[i] == stage3_r[i]) ? stage3_r[i]
                                                           : pinOut[i];
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1_r <= RST_VAL;
      stage2_r <= RST_VAL;
      stage3_r <= RST_VAL;
      pinOut   <= RST_VAL;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      pinOut   <= pinOut_nxt;
    end
  end

endmodule

// ==== bpsio_port.sv ====
// Soft input/output port on the low-speed bus, select region two.
// Assumes bus pins, jumpers and switch are asynchronous to mclk.
`timescale 1ns/100ps
module bpsio_port
  import bpsio_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // Low-speed bus
  input  wire logic                busEnable,
  input  wire logic                lowspeedSelectRegionTwoN,
  input  wire logic                readStrobeN,
  input  wire logic                writeStrobeN,
  input  wire logic [DATA_W-1:0]   dataIn,
  output logic      [DATA_W-1:0]   dataOut_r,
  output logic                     dataOe_r,
  // Bracket panel and board inputs
  input  wire logic                jumperPeripheralAccess,
  input  wire logic                jumperOptionB,
  input  wire logic                jumperOptionC,
  input  wire logic [SWITCH_W-1:0] switchPosition,
  // Lamps, active low
  output logic                     redLampN_r,
  output logic                     greenLampN_r,
  output logic                     amberLampN_r
);

  // ----------------------------------------------------------------
  // Input filtering
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0]   pinRaw;
  logic [SYNC_W-1:0]   pinSync;
  logic                enSync;
  logic                selNSync;
  logic                rdNSync;
  logic                wrNSync;
  logic [JUMPER_W-1:0] jumperSync;
  logic [SWITCH_W-1:0] switchSync;
  logic [DATA_W-1:0]   dataSync;

  assign pinRaw = {busEnable, lowspeedSelectRegionTwoN, readStrobeN,
                   writeStrobeN, jumperPeripheralAccess, jumperOptionB,
                   jumperOptionC, switchPosition, dataIn};

  bpsio_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) uSync (
    .mclk   (mclk),
    .rst    (rst),
    .pinIn  (pinRaw),
    .pinOut (pinSync)
  );

  assign {enSync, selNSync, rdNSync, wrNSync,
          jumperSync, switchSync, dataSync} = pinSync;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Enable filter resets low, so no access lands until software enables
  logic               access;
  logic               writeTake;
  logic               readActive;
  logic               wrNPrev_r;
  logic               toggle_r;
  logic [DATA_W-1:0]  readWord;

  assign access     = enSync & ~selNSync;
  // Write taken at strobe release, when the data has settled longest
  assign writeTake  = access & wrNSync & ~wrNPrev_r;
  assign readActive = access & ~rdNSync & wrNSync;
  // Live jumper levels and inverted switch levels, no latching; bit 7 is the stored toggle; lamp state is never returned
  assign readWord   = {toggle_r, jumperSync,
                       ~switchSync};

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  // Data bits 6 to 3 are not stored anywhere
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrNPrev_r    <= 1'b1;
      toggle_r     <= TOGGLE_RST;
      redLampN_r   <= LAMP_OFF;
      greenLampN_r <= LAMP_OFF;
      amberLampN_r <= LAMP_OFF;
    end else begin
      wrNPrev_r <= wrNSync;
      if (writeTake) begin
        toggle_r     <= dataSync[TOGGLE_BIT];
        redLampN_r   <= dataSync[RED_BIT];
        greenLampN_r <= dataSync[GREEN_BIT];
        amberLampN_r <= dataSync[AMBER_BIT];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dataOut_r <= '0;
      dataOe_r  <= 1'b0;
    end else begin
      dataOut_r <= readWord;
      dataOe_r  <= readActive;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_toggle_store: assert property (@(posedge mclk) disable iff (rst)
    writeTake |=> toggle_r == $past(dataSync[TOGGLE_BIT]) ##1
                  dataOut_r[TOGGLE_BIT] == $past(toggle_r))
    else $error("Scratch bit not stored or read back");

  a_red_lamp: assert property (@(posedge mclk) disable iff (rst)
    writeTake |=> redLampN_r == $past(dataSync[RED_BIT]))
    else $error("Red lamp does not follow write bit");

  a_green_lamp: assert property (@(posedge mclk) disable iff (rst)
    writeTake |=> greenLampN_r == $past(dataSync[GREEN_BIT]))
    else $error("Green lamp does not follow write bit");

  a_amber_lamp: assert property (@(posedge mclk) disable iff (rst)
    writeTake |=> amberLampN_r == $past(dataSync[AMBER_BIT]))
    else $error("Amber lamp does not follow write bit");

  a_lamps_hold: assert property (@(posedge mclk) disable iff (rst)
    !writeTake |=> $stable({toggle_r, redLampN_r, greenLampN_r,
                            amberLampN_r}))
    else $error("Port state changed without a write");

  a_jumper_live: assert property (@(posedge mclk) disable iff (rst)
    dataOe_r |-> dataOut_r[JUMPER_LSB +: JUMPER_W] == $past(jumperSync))
    else $error("Jumper bits not live");

  a_switch_invert: assert property (@(posedge mclk) disable iff (rst)
    dataOe_r |-> dataOut_r[SWITCH_LSB +: SWITCH_W] == ~$past(switchSync))
    else $error("Switch nibble not inverted");

  a_bus_disabled: assert property (@(posedge mclk) disable iff (rst)
    !enSync |=> !dataOe_r && $stable(redLampN_r))
    else $error("Access while low-speed bus disabled");

  a_alias_decode: assert property (@(posedge mclk) disable iff (rst)
    (enSync && !selNSync && !rdNSync && wrNSync) |=> dataOe_r)
    else $error("Selected read not answered");

endmodule

// ==== bpsio_host.sv ====
// Bus controller model driving the soft port.
// Assumes mclk; drives 1 ns after each edge.
`timescale 1ns/100ps
module bpsio_host
  import bpsio_pkg::*;
(
  // Clock
  input  wire logic              mclk,
  // Low-speed bus
  output logic                   selN,
  output logic                   rdN,
  output logic                   wrN,
  output logic      [DATA_W-1:0] wd,
  input  wire logic [DATA_W-1:0] rd,
  input  wire logic              oe
);
  // -----------------
  // Bus cycles
  // -----------------
  initial begin
    selN = 1'h1;
    rdN  = 1'h1;
    wrN  = 1'h1;
    wd   = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Select, strobes and write data only; bus enable belongs to the bench
  task automatic put(input logic [7:0] v, input logic s);
    cyc(1);
    selN = s;
    wd   = v;
    cyc(1);
    wrN  = 1'h0;
    cyc(5);
    wrN  = 1'h1;
    cyc(2);
    selN = 1'h1;
    // Released data shows the inverse, not the last value
    wd   = ~v;
    cyc(6);
  endtask
  // Read word taken well after the answer has settled
  task automatic get(output logic [7:0] v, output logic e);
    cyc(1);
    selN = 1'h0;
    rdN  = 1'h0;
    cyc(7);
    v    = rd;
    e    = oe;
    rdN  = 1'h1;
    selN = 1'h1;
    cyc(6);
  endtask
endmodule

// ==== bracket_panel_soft_io_port_test.sv ====
// Self-checking bench for the soft port.
// Assumes bpsio_host as the bus controller.
`timescale 1ns/100ps
module bracket_panel_soft_io_port_test;
  import bpsio_pkg::*;
  logic       mclk, rst, busEnable, selN, rdN, wrN;
  logic [7:0] wd, dOut, v, w;
  logic       dOe, jA, jB, jC, red, green, amber, e;
  logic [3:0] sw;
  int         numErrors, checksDone, cycles;
  // -----------------
  // Harness
  // -----------------
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  bpsio_host u_host (.mclk(mclk), .selN(selN), .rdN(rdN),
    .wrN(wrN), .wd(wd), .rd(dOut), .oe(dOe));
  bpsio_port u_dut (.mclk(mclk), .rst(rst), .busEnable(busEnable),
    .lowspeedSelectRegionTwoN(selN), .readStrobeN(rdN),
    .writeStrobeN(wrN), .dataIn(wd), .dataOut_r(dOut),
    .dataOe_r(dOe), .jumperPeripheralAccess(jA),
    .jumperOptionB(jB), .jumperOptionC(jC), .switchPosition(sw),
    .redLampN_r(red), .greenLampN_r(green), .amberLampN_r(amber));
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    checksDone++;
    if (g !== x) begin
      numErrors++;
      $display("[FAIL] %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic report_and_stop();
    if (numErrors == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Run is about 615 cycles, so 5000 means a hang
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 32'h0000_1388) begin
      numErrors++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop();
    end
  end
  // -----------------
  // Tests
  // -----------------
  initial begin
    rst = 1'h1;
    busEnable = 1'h0;
    {jA, jB, jC} = 3'h0;
    sw = 4'h0;
    repeat (8) @(posedge mclk);
    #1 rst = 1'h0;
    u_host.put(8'h00, 1'h0);
    chk({5'h00, red, green, amber}, 8'h07);
    u_host.get(v, e);
    chk({7'h00, e}, 8'h00);
    busEnable = 1'h1;
    w = 8'h5a;
    for (int i = 0; i < 16; i++) begin
      w = w + 8'h93;
      u_host.put(w, 1'h0);
      chk({5'h00, red, green, amber}, {5'h00, w[2:0]});
      // Pins move after the write; reads must follow them
      sw = i[3:0];
      {jA, jB, jC} = i[2:0];
      u_host.cyc(5);
      u_host.get(v, e);
      chk(v, {w[7], i[2:0], ~i[3:0]});
      chk({7'h00, e}, 8'h01);
    end
    u_host.put(~w, 1'h1);
    chk({5'h00, red, green, amber}, {5'h00, w[2:0]});
    busEnable = 1'h0;
    u_host.cyc(5);
    u_host.get(v, e);
    chk({7'h00, e}, 8'h00);
    report_and_stop();
  end
endmodule
